// ### verilog/spg_pkg.sv
package spg_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [15:0] OFS_PORT_D_DATA    = 16'h0003;
  localparam logic [15:0] OFS_PORT_E_DATA    = 16'h0008;
  localparam logic [15:0] OFS_PORT_F_DATA    = 16'h0440;
  localparam logic [15:0] OFS_PORT_D_DIR     = 16'h0007;
  localparam logic [15:0] OFS_PORT_E_DIR     = 16'h000C;
  localparam logic [15:0] OFS_PORT_F_DIR     = 16'h0444;
  localparam logic [15:0] OFS_PORT_D_PULLUP  = 16'h000D;
  localparam logic [15:0] OFS_PERIPH_CTRL    = 16'h0450;
  // Peripheral control field positions
  localparam int unsigned CTRL_SPI_EN_POS    = 0;
  localparam int unsigned CTRL_SPI_MSTR_POS  = 1;
  localparam int unsigned CTRL_SCI_EN_POS    = 2;
  // Widths and reset values
  localparam int unsigned PORT_D_W = 8;
  localparam int unsigned PORT_E_W = 6;
  localparam int unsigned PORT_F_W = 8;
  localparam int unsigned TIM_CH_N = 4;
  localparam int unsigned TIM_ELS_W = 2;
  localparam logic [7:0] DIR_RST    = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [1:0] ELS_GPIO   = 2'h0;
  // Pin positions of shared functions
  localparam int unsigned PD_SS_POS    = 0;
  localparam int unsigned PD_MISO_POS  = 1;
  localparam int unsigned PD_MOSI_POS  = 2;
  localparam int unsigned PD_SCK_POS   = 3;
  localparam int unsigned PE_TXD_POS   = 0;
  localparam int unsigned PE_RXD_POS   = 1;
  localparam int unsigned PF_TIM_LO    = 4;
endpackage : spg_pkg

// ### verilog/spg_pin_bank.sv
`timescale 1ns/1ns
module spg_pin_bank #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             CORE_CLK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic             CLK_EN_IN,
  input  wire logic             data_we_in,
  input  wire logic             dir_we_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] own_in,
  input  wire logic [WIDTH-1:0] own_oe_in,
  input  wire logic [WIDTH-1:0] own_dout_in,
  output logic      [WIDTH-1:0] latch_out,
  output logic      [WIDTH-1:0] dir_out,
  output logic      [WIDTH-1:0] read_out,
  output logic      [WIDTH-1:0] pin_oe_out,
  output logic      [WIDTH-1:0] pin_dout_out
);
  logic [WIDTH-1:0] latch_ff;
  logic [WIDTH-1:0] dir_ff;

  // Width must fit the byte-wide bus
  if (WIDTH < 1 || WIDTH > 8) begin : g_width_chk
    $error("spg_pin_bank: WIDTH must be 1 to 8");
  end

  // Latch has no reset; write ignores direction
  always_ff @(posedge CORE_CLK_IN) begin
    if (CLK_EN_IN && data_we_in) begin
      latch_ff <= wdata_in[WIDTH-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dir_ff <= spg_pkg::DIR_RST[WIDTH-1:0];
    end else if (CLK_EN_IN && dir_we_in) begin
      dir_ff <= wdata_in[WIDTH-1:0];
    end
  end

  always_comb begin
    read_out     = (dir_ff & latch_ff) | (~dir_ff & pin_in);
    pin_oe_out   = (own_in & own_oe_in) | (~own_in & dir_ff);
    pin_dout_out = (own_in & own_dout_in) | (~own_in & latch_ff);
  end

  assign latch_out = latch_ff;
  assign dir_out   = dir_ff;
endmodule : spg_pin_bank

// ### verilog/spg_gpio_top.sv
`timescale 1ns/1ns
// Functional notes
// - SPI disabled: master-in/slave-out pin is plain port D I/O.
// - Slave-select pin is I/O when SPI off or master mode set.
// - With SPI enabled and master mode clear, direction bit 0 ignored on slave-select.
// - Port D direction ignored on SPI pins but still selects readback.
// - Port D direction 1 drives output buffer, 0 leaves input.
// - Reset clears all port D direction bits.
// - Port D read gives latch for outputs, pin for inputs.
// - Data latches always writable; inputs read pin regardless.
// - Port E and F data latches untouched by reset.
// - Port D pullup only when enabled and pin is input.
// - Port D pullup enable has one writable bit per pin.
// - Port E is six bits, two shared with serial interface.
// - Serial off: port E bit 1 is I/O, not receive input.
// - Serial off: port E bit 0 is I/O, not transmit output.
// - Port E direction ignored on serial pins, still selects readback.
// - Reset clears port E direction; 1 enables output buffer.
// - Port E read gives latch for outputs, pin for inputs.
// - Port F eight bits, upper four shared with timer channels.
// - Timer edge/level select decides timer or I/O per pin.
// - Port F read gives latch for outputs, pin for inputs.
// - Reset clears all port F direction bits.
module spg_gpio_top (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  input  wire logic [7:0]  PORT_D_PIN_IN,
  output logic      [7:0]  PORT_D_PIN_OUT,
  output logic      [7:0]  PORT_D_OE_OUT,
  output logic      [7:0]  PORT_D_PULLUP_OUT,
  input  wire logic [5:0]  PORT_E_PIN_IN,
  output logic      [5:0]  PORT_E_PIN_OUT,
  output logic      [5:0]  PORT_E_OE_OUT,
  input  wire logic [7:0]  PORT_F_PIN_IN,
  output logic      [7:0]  PORT_F_PIN_OUT,
  output logic      [7:0]  PORT_F_OE_OUT,
  input  wire logic        SPI_MISO_OE_IN,
  input  wire logic        SPI_MISO_DOUT_IN,
  input  wire logic        SPI_MOSI_OE_IN,
  input  wire logic        SPI_MOSI_DOUT_IN,
  input  wire logic        SPI_SCK_OE_IN,
  input  wire logic        SPI_SCK_DOUT_IN,
  output logic             SPI_ENABLE_OUT,
  output logic             SPI_MASTER_OUT,
  output logic             SPI_MISO_OUT,
  output logic             SPI_MOSI_OUT,
  output logic             SPI_SCK_OUT,
  output logic             SPI_SS_N_OUT,
  input  wire logic        SCI_TXD_IN,
  output logic             SCI_ENABLE_OUT,
  output logic             SCI_RXD_OUT,
  input  wire logic [7:0]  TIM_ELS_IN,
  input  wire logic [3:0]  TIM_CH_OE_IN,
  input  wire logic [3:0]  TIM_CH_DOUT_IN,
  output logic      [3:0]  TIM_CH_OUT
);
  logic [7:0] pullup_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] rdata_ff;
  logic       spi_en;
  logic       spi_mstr;
  logic       sci_en;
  logic [7:0] d_own;
  logic [7:0] d_own_oe;
  logic [7:0] d_own_dout;
  logic [5:0] e_own;
  logic [5:0] e_own_oe;
  logic [5:0] e_own_dout;
  logic [7:0] f_own;
  logic [7:0] f_own_oe;
  logic [7:0] f_own_dout;
  logic [7:0] d_latch;
  logic [7:0] d_dir;
  logic [7:0] d_read;
  logic [5:0] e_latch;
  logic [5:0] e_dir;
  logic [5:0] e_read;
  logic [7:0] f_latch;
  logic [7:0] f_dir;
  logic [7:0] f_read;
  logic [7:0] nxt_rdata;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [7:0] pad6(input logic [5:0] v);
    pad6 = {2'h0, v};
  endfunction : pad6

  // Package widths must fit the pin ports
  if (spg_pkg::PORT_D_W != 8 || spg_pkg::PORT_F_W != 8 ||
      spg_pkg::PORT_E_W != 6) begin : g_width_chk
    $error("spg_gpio_top: package widths do not match ports");
  end

  assign spi_en   = ctrl_ff[spg_pkg::CTRL_SPI_EN_POS];
  assign spi_mstr = ctrl_ff[spg_pkg::CTRL_SPI_MSTR_POS];
  assign sci_en   = ctrl_ff[spg_pkg::CTRL_SCI_EN_POS];

  always_comb begin
    d_own      = 8'h00;
    d_own_oe   = 8'h00;
    d_own_dout = 8'h00;
    d_own[spg_pkg::PD_MISO_POS] = spi_en;
    d_own[spg_pkg::PD_MOSI_POS] = spi_en;
    d_own[spg_pkg::PD_SCK_POS]  = spi_en;
    d_own[spg_pkg::PD_SS_POS]   = spi_en && !spi_mstr;
    d_own_oe[spg_pkg::PD_MISO_POS]   = SPI_MISO_OE_IN;
    d_own_dout[spg_pkg::PD_MISO_POS] = SPI_MISO_DOUT_IN;
    d_own_oe[spg_pkg::PD_MOSI_POS]   = SPI_MOSI_OE_IN;
    d_own_dout[spg_pkg::PD_MOSI_POS] = SPI_MOSI_DOUT_IN;
    d_own_oe[spg_pkg::PD_SCK_POS]    = SPI_SCK_OE_IN;
    d_own_dout[spg_pkg::PD_SCK_POS]  = SPI_SCK_DOUT_IN;
  end

  always_comb begin
    e_own      = 6'h00;
    e_own_oe   = 6'h00;
    e_own_dout = 6'h00;
    e_own[spg_pkg::PE_RXD_POS]      = sci_en;
    e_own[spg_pkg::PE_TXD_POS]      = sci_en;
    e_own_oe[spg_pkg::PE_TXD_POS]   = 1'b1;
    e_own_dout[spg_pkg::PE_TXD_POS] = SCI_TXD_IN;
  end

  always_comb begin
    f_own      = 8'h00;
    f_own_oe   = 8'h00;
    f_own_dout = 8'h00;
    for (int i = 0; i < spg_pkg::TIM_CH_N; i++) begin
      f_own[spg_pkg::PF_TIM_LO + i] =
        TIM_ELS_IN[2*i +: 2] != spg_pkg::ELS_GPIO;
      f_own_oe[spg_pkg::PF_TIM_LO + i]   = TIM_CH_OE_IN[i];
      f_own_dout[spg_pkg::PF_TIM_LO + i] = TIM_CH_DOUT_IN[i];
    end
  end

  // Port D bank with reset dir
  spg_pin_bank #(.WIDTH(spg_pkg::PORT_D_W)) u_port_d (
    .CORE_CLK_IN  (CORE_CLK_IN),
    .RST_N_IN     (RST_N_IN),
    .CLK_EN_IN    (CLK_EN_IN),
    .data_we_in   (WR_IN && hit(ADDR_IN, spg_pkg::OFS_PORT_D_DATA)),
    .dir_we_in    (WR_IN && hit(ADDR_IN, spg_pkg::OFS_PORT_D_DIR)),
    .wdata_in     (WDATA_IN),
    .pin_in       (PORT_D_PIN_IN),
    .own_in       (d_own),
    .own_oe_in    (d_own_oe),
    .own_dout_in  (d_own_dout),
    .latch_out    (d_latch),
    .dir_out      (d_dir),
    .read_out     (d_read),
    .pin_oe_out   (PORT_D_OE_OUT),
    .pin_dout_out (PORT_D_PIN_OUT)
  );

  spg_pin_bank #(.WIDTH(spg_pkg::PORT_E_W)) u_port_e (
    .CORE_CLK_IN  (CORE_CLK_IN),
    .RST_N_IN     (RST_N_IN),
    .CLK_EN_IN    (CLK_EN_IN),
    .data_we_in   (WR_IN && hit(ADDR_IN, spg_pkg::OFS_PORT_E_DATA)),
    .dir_we_in    (WR_IN && hit(ADDR_IN, spg_pkg::OFS_PORT_E_DIR)),
    .wdata_in     (WDATA_IN),
    .pin_in       (PORT_E_PIN_IN),
    .own_in       (e_own),
    .own_oe_in    (e_own_oe),
    .own_dout_in  (e_own_dout),
    .latch_out    (e_latch),
    .dir_out      (e_dir),
    .read_out     (e_read),
    .pin_oe_out   (PORT_E_OE_OUT),
    .pin_dout_out (PORT_E_PIN_OUT)
  );

  spg_pin_bank #(.WIDTH(spg_pkg::PORT_F_W)) u_port_f (
    .CORE_CLK_IN  (CORE_CLK_IN),
    .RST_N_IN     (RST_N_IN),
    .CLK_EN_IN    (CLK_EN_IN),
    .data_we_in   (WR_IN && hit(ADDR_IN, spg_pkg::OFS_PORT_F_DATA)),
    .dir_we_in    (WR_IN && hit(ADDR_IN, spg_pkg::OFS_PORT_F_DIR)),
    .wdata_in     (WDATA_IN),
    .pin_in       (PORT_F_PIN_IN),
    .own_in       (f_own),
    .own_oe_in    (f_own_oe),
    .own_dout_in  (f_own_dout),
    .latch_out    (f_latch),
    .dir_out      (f_dir),
    .read_out     (f_read),
    .pin_oe_out   (PORT_F_OE_OUT),
    .pin_dout_out (PORT_F_PIN_OUT)
  );

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pullup_ff <= spg_pkg::PULLUP_RST;
    end else if (CLK_EN_IN && WR_IN &&
                 hit(ADDR_IN, spg_pkg::OFS_PORT_D_PULLUP)) begin
      pullup_ff <= WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_ff <= spg_pkg::CTRL_RST;
    end else if (CLK_EN_IN && WR_IN &&
                 hit(ADDR_IN, spg_pkg::OFS_PERIPH_CTRL)) begin
      ctrl_ff <= {5'h00, WDATA_IN[2:0]};
    end
  end

  assign PORT_D_PULLUP_OUT = pullup_ff & ~d_dir & ~PORT_D_OE_OUT;

  always_comb begin
    nxt_rdata = 8'h00;
    case (1'b1)
      hit(ADDR_IN, spg_pkg::OFS_PORT_D_DATA):   nxt_rdata = d_read;
      hit(ADDR_IN, spg_pkg::OFS_PORT_E_DATA):   nxt_rdata = pad6(e_read);
      hit(ADDR_IN, spg_pkg::OFS_PORT_F_DATA):   nxt_rdata = f_read;
      hit(ADDR_IN, spg_pkg::OFS_PORT_D_DIR):    nxt_rdata = d_dir;
      hit(ADDR_IN, spg_pkg::OFS_PORT_E_DIR):    nxt_rdata = pad6(e_dir);
      hit(ADDR_IN, spg_pkg::OFS_PORT_F_DIR):    nxt_rdata = f_dir;
      hit(ADDR_IN, spg_pkg::OFS_PORT_D_PULLUP): nxt_rdata = pullup_ff;
      hit(ADDR_IN, spg_pkg::OFS_PERIPH_CTRL):   nxt_rdata = ctrl_ff;
      default:                                  nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_ff <= 8'h00;
    end else if (CLK_EN_IN) begin
      rdata_ff <= RD_IN ? nxt_rdata : 8'h00;
    end
  end

  assign RDATA_OUT      = rdata_ff;
  assign SPI_ENABLE_OUT = spi_en;
  assign SPI_MASTER_OUT = spi_mstr;
  assign SPI_MISO_OUT   = PORT_D_PIN_IN[spg_pkg::PD_MISO_POS];
  assign SPI_MOSI_OUT   = PORT_D_PIN_IN[spg_pkg::PD_MOSI_POS];
  assign SPI_SCK_OUT    = PORT_D_PIN_IN[spg_pkg::PD_SCK_POS];
  assign SPI_SS_N_OUT   = d_own[spg_pkg::PD_SS_POS] ?
                          PORT_D_PIN_IN[spg_pkg::PD_SS_POS] : 1'b1;
  assign SCI_ENABLE_OUT = sci_en;
  assign SCI_RXD_OUT    = sci_en ? PORT_E_PIN_IN[spg_pkg::PE_RXD_POS] : 1'b1;
  assign TIM_CH_OUT     = PORT_F_PIN_IN[7:4];
endmodule : spg_gpio_top

// ### verif/spg_gpio_props.sv
`timescale 1ns/1ns
module spg_gpio_props (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        CLK_EN_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic [7:0]  PORT_D_OE_OUT,
  input wire logic [7:0]  PORT_D_PULLUP_OUT,
  input wire logic [5:0]  PORT_E_OE_OUT,
  input wire logic [7:0]  PORT_F_OE_OUT,
  input wire logic        SPI_MISO_OE_IN,
  input wire logic        SPI_ENABLE_OUT,
  input wire logic        SPI_MASTER_OUT,
  input wire logic        SPI_SS_N_OUT,
  input wire logic        SCI_ENABLE_OUT,
  input wire logic        SCI_RXD_OUT,
  input wire logic [7:0]  TIM_ELS_IN,
  input wire logic [3:0]  TIM_CH_OE_IN
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire wd = WR_IN && CLK_EN_IN && ADDR_IN == spg_pkg::OFS_PORT_D_DIR;
  dir_rst_a: assert property ($rose(RST_N_IN) |->
    {PORT_D_OE_OUT, PORT_E_OE_OUT, PORT_D_PULLUP_OUT} == 22'h0)
    else $error("outputs not idle after reset");
  ddir_wr_a: assert property (wd && !SPI_ENABLE_OUT |=>
    PORT_D_OE_OUT == $past(WDATA_IN)) else $error("port D enable wrong");
  pullup_off_a: assert property (wd |=>
    (PORT_D_PULLUP_OUT & $past(WDATA_IN)) == 8'h00)
    else $error("pullup on output pin");
  rd_idle_a: assert property (CLK_EN_IN && !RD_IN |=>
    RDATA_OUT == 8'h00) else $error("read data without read");
  e_width_a: assert property (RD_IN && CLK_EN_IN &&
    ADDR_IN == spg_pkg::OFS_PORT_E_DATA |=> RDATA_OUT[7:6] == 2'h0)
    else $error("port E upper bits set");
  ss_gpio_a: assert property (!SPI_ENABLE_OUT || SPI_MASTER_OUT |->
    SPI_SS_N_OUT) else $error("select active while not owned");
  ss_noout_a: assert property (SPI_ENABLE_OUT && !SPI_MASTER_OUT |->
    !PORT_D_OE_OUT[0]) else $error("select pin driven");
  miso_own_a: assert property (SPI_ENABLE_OUT |->
    PORT_D_OE_OUT[1] == SPI_MISO_OE_IN) else $error("miso enable wrong");
  rxd_gpio_a: assert property (!SCI_ENABLE_OUT |-> SCI_RXD_OUT)
    else $error("receive input not idle");
  rxd_in_a: assert property (SCI_ENABLE_OUT |-> !PORT_E_OE_OUT[1])
    else $error("receive pin driven");
  tim_own_a: assert property (TIM_ELS_IN[1:0] != 2'h0 |->
    PORT_F_OE_OUT[4] == TIM_CH_OE_IN[0]) else $error("timer enable wrong");
endmodule : spg_gpio_props
bind spg_gpio_top spg_gpio_props u_props (.*);

// ### verif/spg_board_pin.sv
`timescale 1ns/1ns
module spg_board_pin #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] dout_in,
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] pu_in,
  input  wire logic [W-1:0] ext_en_in,
  input  wire logic [W-1:0] ext_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] flt_ff = '0;
  // Floating pins wander
  always_ff @(posedge clk_in) begin
    flt_ff <= ~flt_ff;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_out[i] = oe_in[i] ? dout_in[i] : ext_en_in[i] ? ext_in[i] :
                     pu_in[i] ? 1'b1 : flt_ff[i];
    end
  end
endmodule : spg_board_pin

// ### verif/tb_shared_pin_gpio_ports_def.sv
`timescale 1ns/1ns
module tb_shared_pin_gpio_ports_def;
  logic CORE_CLK_IN = 0, RST_N_IN = 0, CLK_EN_IN = 1, WR_IN = 0, RD_IN = 0;
  logic [15:0] ADDR_IN = 0;
  logic [7:0] WDATA_IN = 0, RDATA_OUT, PORT_D_PIN_IN, PORT_D_PIN_OUT;
  logic [7:0] PORT_D_OE_OUT, PORT_D_PULLUP_OUT, PORT_F_PIN_IN;
  logic [7:0] PORT_F_PIN_OUT, PORT_F_OE_OUT, TIM_ELS_IN = 0;
  logic [5:0] PORT_E_PIN_IN, PORT_E_PIN_OUT, PORT_E_OE_OUT, xe = 6'h15;
  logic SPI_MISO_OE_IN = 0, SPI_MISO_DOUT_IN = 0, SPI_MOSI_OE_IN = 1;
  logic SPI_MOSI_DOUT_IN = 1, SPI_SCK_OE_IN = 0, SPI_SCK_DOUT_IN = 0;
  logic SPI_ENABLE_OUT, SPI_MASTER_OUT, SPI_MISO_OUT, SPI_MOSI_OUT;
  logic SPI_SCK_OUT, SPI_SS_N_OUT, SCI_TXD_IN = 1, SCI_ENABLE_OUT;
  logic SCI_RXD_OUT;
  logic [3:0] TIM_CH_OE_IN = 0, TIM_CH_DOUT_IN = 0, TIM_CH_OUT;
  logic [7:0] xen = 8'hFF, xd = 8'h3C, xf = 8'h5A;
  int err_count = 0, num_checks = 0;
  localparam logic [15:0] AD = spg_pkg::OFS_PORT_D_DATA;
  localparam logic [15:0] AE = spg_pkg::OFS_PORT_E_DATA;
  localparam logic [15:0] AF = spg_pkg::OFS_PORT_F_DATA;
  localparam logic [15:0] DD = spg_pkg::OFS_PORT_D_DIR;
  localparam logic [15:0] DE = spg_pkg::OFS_PORT_E_DIR;
  localparam logic [15:0] DF = spg_pkg::OFS_PORT_F_DIR;
  localparam logic [15:0] PU = spg_pkg::OFS_PORT_D_PULLUP;
  localparam logic [15:0] CT = spg_pkg::OFS_PERIPH_CTRL;
  spg_gpio_top uut (.*);
  spg_board_pin #(.W(8)) u_pd (.clk_in(CORE_CLK_IN),
    .dout_in(PORT_D_PIN_OUT), .oe_in(PORT_D_OE_OUT),
    .pu_in(PORT_D_PULLUP_OUT), .ext_en_in(xen), .ext_in(xd),
    .level_out(PORT_D_PIN_IN));
  spg_board_pin #(.W(6)) u_pe (.clk_in(CORE_CLK_IN),
    .dout_in(PORT_E_PIN_OUT), .oe_in(PORT_E_OE_OUT), .pu_in(6'h00),
    .ext_en_in(xen[5:0]), .ext_in(xe), .level_out(PORT_E_PIN_IN));
  spg_board_pin #(.W(8)) u_pf (.clk_in(CORE_CLK_IN),
    .dout_in(PORT_F_PIN_OUT), .oe_in(PORT_F_OE_OUT), .pu_in(8'h00),
    .ext_en_in(xen), .ext_in(xf), .level_out(PORT_F_PIN_IN));
  initial begin
    forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_IN);
    WR_IN <= 1; ADDR_IN <= a; WDATA_IN <= d;
    @(posedge CORE_CLK_IN);
    WR_IN <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK_IN);
    RD_IN <= 1; ADDR_IN <= a;
    @(posedge CORE_CLK_IN);
    RD_IN <= 0;
    #1 chk(RDATA_OUT, exp);
  endtask : rd
  task automatic do_reset();
    RST_N_IN <= 0;
    repeat (5) @(posedge CORE_CLK_IN);
    RST_N_IN <= 1;
  endtask : do_reset
  task automatic t_reset();
    rd(DD, 8'h00);
    rd(DE, 8'h00);
    rd(DF, 8'h00);
    rd(PU, 8'h00);
  endtask : t_reset
  task automatic t_gpio();
    wr(AD, 8'hA5);
    wr(DD, 8'h0F);
    chk(PORT_D_OE_OUT, 8'h0F);
    chk(PORT_D_PIN_OUT & 8'h0F, 8'h05);
    rd(AD, 8'h35);
    wr(AD, 8'hFF);
    rd(AD, 8'h3F);
    wr(PU, 8'hFF);
    chk(PORT_D_PULLUP_OUT, 8'hF0);
    rd(PU, 8'hFF);
    wr(AE, 8'h2A);
    wr(DE, 8'h03);
    chk({2'h0, PORT_E_OE_OUT}, 8'h03);
    rd(AE, 8'h16);
    wr(AF, 8'h96);
    wr(DF, 8'h0F);
    chk(PORT_F_OE_OUT, 8'h0F);
    chk(PORT_F_PIN_OUT, 8'h96);
    rd(AF, 8'h56);
    wr(16'h0100, 8'hFF);
    rd(16'h0100, 8'h00);
  endtask : t_gpio
  task automatic t_freeze();
    @(posedge CORE_CLK_IN);
    CLK_EN_IN <= 1'b0;
    wr(PU, 8'h00);
    @(posedge CORE_CLK_IN);
    CLK_EN_IN <= 1'b1;
    rd(PU, 8'hFF);
  endtask : t_freeze
  task automatic t_spi();
    wr(DD, 8'hFF);
    wr(CT, 8'h01);
    chk(PORT_D_OE_OUT, 8'hF4);
    chk({6'h0, SPI_MASTER_OUT, SPI_ENABLE_OUT}, 8'h01);
    chk({5'h0, SPI_SCK_OUT, SPI_MOSI_OUT, SPI_MISO_OUT}, 8'h06);
    rd(AD, 8'hFF);
    chk({7'h0, SPI_SS_N_OUT}, 8'h00);
    @(posedge CORE_CLK_IN);
    SPI_MISO_OE_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    #1 chk(PORT_D_OE_OUT, 8'hF6);
    @(posedge CORE_CLK_IN);
    SPI_MISO_OE_IN <= 1'b0;
    wr(CT, 8'h03);
    chk(PORT_D_OE_OUT, 8'hF5);
    chk({7'h0, SPI_SS_N_OUT}, 8'h01);
    wr(CT, 8'h00);
    chk(PORT_D_OE_OUT, 8'hFF);
  endtask : t_spi
  task automatic t_sci();
    wr(CT, 8'h04);
    chk({7'h0, SCI_ENABLE_OUT}, 8'h01);
    chk({7'h0, PORT_E_OE_OUT[1]}, 8'h00);
    chk({7'h0, SCI_RXD_OUT}, 8'h00);
    chk({7'h0, PORT_E_PIN_OUT[0]}, 8'h01);
    rd(AE, 8'h16);
    wr(CT, 8'h00);
    chk({7'h0, SCI_RXD_OUT}, 8'h01);
    chk({2'h0, PORT_E_OE_OUT}, 8'h03);
  endtask : t_sci
  task automatic t_tim();
    wr(DF, 8'h00);
    @(posedge CORE_CLK_IN);
    TIM_ELS_IN   <= 8'h01;
    TIM_CH_OE_IN <= 4'h1;
    @(posedge CORE_CLK_IN);
    #1 chk(PORT_F_OE_OUT, 8'h10);
    chk({4'h0, TIM_CH_OUT}, 8'h04);
    @(posedge CORE_CLK_IN);
    TIM_ELS_IN   <= 8'hC0;
    TIM_CH_OE_IN <= 4'h8;
    @(posedge CORE_CLK_IN);
    #1 chk(PORT_F_OE_OUT, 8'h80);
    @(posedge CORE_CLK_IN);
    TIM_ELS_IN <= 8'h00;
    @(posedge CORE_CLK_IN);
    #1 chk(PORT_F_OE_OUT, 8'h00);
  endtask : t_tim
  task automatic t_keep();
    @(posedge CORE_CLK_IN);
    do_reset();
    rd(DD, 8'h00);
    rd(DE, 8'h00);
    wr(DE, 8'h3F);
    rd(AE, 8'h2A);
    wr(DF, 8'hFF);
    rd(AF, 8'h96);
  endtask : t_keep
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    err_count++;
    close_out();
  end
  initial begin
    do_reset();
    t_reset();
    t_gpio();
    t_freeze();
    t_spi();
    t_sci();
    t_tim();
    t_keep();
    close_out();
  end
endmodule : tb_shared_pin_gpio_ports_def
